// ---- design/sdl_top.sv ----
// Purpose: Serial load port of a multi-channel DAC with double-buffered latches
// Assumes: Host supplies serial clock, data, frame sync and load strobe
// Notes:   Output latches exposed as flat buses; channel count is a parameter
`timescale 1ns/100ps
module sdl_top
	import sdl_pkg::*;
#(
	parameter int CHANNELS = 8
)(
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  serial_clock_in_i,
	input  wire logic                  serial_data_in_i,
	input  wire logic                  frame_sync_n_i,
	input  wire logic                  load_outputs_n_i,
	input  wire logic                  clear_outputs_n_i,
	output logic [CHANNELS*10-1:0]     dac_main_o,
	output logic [CHANNELS*10-1:0]     dac_sub_o,
	output logic [CHANNELS*10-1:0]     chan_ctrl_o,
	output logic [9:0]                 sys_ctrl_o
);
	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	logic                 word_vld;
	logic [WORD_BITS-1:0] word;
	logic [2:0]           sel;
	logic [2:0]           chan;
	logic [9:0]           pay;

	sdl_shift_rx u_rx (
		.ref_clk_i         (ref_clk_i),
		.rst_i             (rst_i),
		.serial_clock_in_i (serial_clock_in_i),
		.serial_data_in_i  (serial_data_in_i),
		.frame_sync_n_i    (frame_sync_n_i),
		.word_vld_o        (word_vld),
		.word_o            (word)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Sub data is eight bits wide; the two upper bits of its lane stay zero
	function automatic logic [9:0] sub_lane(input logic [9:0] p);
		return {2'h0, p[7:0]};
	endfunction

	// Channel numbers beyond the configured count address nothing
	function automatic logic chan_in_range(input logic [2:0] c);
		return 32'(c) < CHANNELS;
	endfunction

	// Lowest bit of a channel's ten-bit lane in the flat buses
	function automatic int lane_lsb(input int c);
		return c * 10;
	endfunction

	// ----------------------------------------
	// Word fields
	// ----------------------------------------
	assign sel  = word[SEL_MSB:SEL_LSB];
	assign chan = word[CHAN_MSB:CHAN_LSB];
	assign pay  = word[PAY_MSB:0];

	// ----------------------------------------
	// Strobe synchronisers
	// ----------------------------------------
	logic [1:0] ld_s_r;
	logic [1:0] clr_s_r;
	logic       ld_d_r;
	logic       ld_fall;
	logic       ld_held;
	logic       clr_now;

	// Idle level is high, so these reset values make no false load edge
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ld_s_r  <= 2'h3;
			clr_s_r <= 2'h3;
			ld_d_r  <= 1'b1;
		end else begin
			ld_s_r  <= {ld_s_r[0], load_outputs_n_i};
			clr_s_r <= {clr_s_r[0], clear_outputs_n_i};
			ld_d_r  <= ld_s_r[1];
		end
	end

	// Only the falling edge copies; a held-low strobe is handled per word
	assign ld_fall = ld_d_r & ~ld_s_r[1];
	assign ld_held = ~ld_s_r[1];
	// Clear is a level: every latch stays at its reset value while low
	assign clr_now = rst_i | ~clr_s_r[1];

	// ----------------------------------------
	// Word decode
	// ----------------------------------------
	logic wr_sys;
	logic wr_chan;
	logic wr_main;
	logic wr_sub;

	always_comb begin
		wr_sys  = 1'b0;
		wr_chan = 1'b0;
		wr_main = 1'b0;
		wr_sub  = 1'b0;
		// Only a complete word is acted on; unknown selects are dropped
		if (word_vld && chan_in_range(chan)) begin
			case (sel)
				SEL_SYS: begin
					wr_sys = 1'b1;
				end
				SEL_CHAN: begin
					wr_chan = 1'b1;
				end
				SEL_MAIN: begin
					wr_main = 1'b1;
				end
				SEL_SUB: begin
					wr_sub = 1'b1;
				end
				default: begin
					wr_sys = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// Control words take effect at once; they are not double buffered
	always_ff @(posedge ref_clk_i) begin
		if (clr_now) begin
			sys_ctrl_o <= CTRL_RST;
		end else if (wr_sys) begin
			sys_ctrl_o <= pay;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (clr_now) begin
			chan_ctrl_o <= {CHANNELS{CTRL_RST}};
		end else if (wr_chan) begin
			chan_ctrl_o[lane_lsb(int'(chan)) +: 10] <= pay;
		end
	end

	// ----------------------------------------
	// Input latches
	// ----------------------------------------
	logic [9:0] in_main_r [CHANNELS];
	logic [9:0] in_sub_r  [CHANNELS];

	always_ff @(posedge ref_clk_i) begin
		if (clr_now) begin
			for (int i = 0; i < CHANNELS; i++) begin
				in_main_r[i] <= DATA_RST;
			end
		end else if (wr_main) begin
			in_main_r[chan] <= pay;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (clr_now) begin
			for (int i = 0; i < CHANNELS; i++) begin
				in_sub_r[i] <= SUB_RST;
			end
		end else if (wr_sub) begin
			in_sub_r[chan] <= sub_lane(pay);
		end
	end

	// ----------------------------------------
	// Output latches
	// ----------------------------------------
	// A load edge copies every channel: cheaper than tracking pending ones,
	// and unwritten channels already match their outputs.
	// A word landing in the same cycle as the edge wins for its channel.
	always_ff @(posedge ref_clk_i) begin
		if (clr_now) begin
			dac_main_o <= {CHANNELS{DATA_RST}};
		end else begin
			if (ld_fall) begin
				for (int i = 0; i < CHANNELS; i++) begin
					dac_main_o[lane_lsb(i) +: 10] <= in_main_r[i];
				end
			end
			if (wr_main && ld_held) begin
				dac_main_o[lane_lsb(int'(chan)) +: 10] <= pay;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (clr_now) begin
			dac_sub_o <= {CHANNELS{SUB_RST}};
		end else begin
			if (ld_fall) begin
				for (int i = 0; i < CHANNELS; i++) begin
					dac_sub_o[lane_lsb(i) +: 10] <= in_sub_r[i];
				end
			end
			if (wr_sub && ld_held) begin
				dac_sub_o[lane_lsb(int'(chan)) +: 10] <= sub_lane(pay);
			end
		end
	end
endmodule

// ---- design/sdl_pkg.sv ----
// Purpose: Constants shared by the serial DAC load interface
// Assumes: 20 MHz reference clock, host-driven serial clock sampled as data
// Notes:   Word layout: top bits select register and channel, rest is payload
package sdl_pkg;
	// ----------------------------------------
	// Word format
	// ----------------------------------------
	localparam int WORD_BITS    = 16;
	localparam int SEL_MSB      = 15;
	localparam int SEL_LSB      = 13;
	localparam int CHAN_MSB     = 12;
	localparam int CHAN_LSB     = 10;
	localparam int PAY_MSB      = 9;
	localparam int CNT_W        = 5;
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
	// ----------------------------------------
	// Register selects
	// ----------------------------------------
	localparam logic [2:0] SEL_SYS  = 3'h0;
	localparam logic [2:0] SEL_MAIN = 3'h1;
	localparam logic [2:0] SEL_CHAN = 3'h2;
	localparam logic [2:0] SEL_SUB  = 3'h5;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [9:0] DATA_RST = 10'h000;
	localparam logic [9:0] CTRL_RST = 10'h000;
	localparam logic [9:0] SUB_RST  = 10'h000;
endpackage

// ---- design/sdl_shift_rx.sv ----
// Purpose: Serial receiver: synchronise pins, shift a 16-bit word MSB first
// Assumes: Serial clock well below half the reference clock rate
// Notes:   Emits a one-cycle word strobe only when all sixteen bits arrived
`timescale 1ns/100ps
module sdl_shift_rx
	import sdl_pkg::*;
(
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 serial_clock_in_i,
	input  wire logic                 serial_data_in_i,
	input  wire logic                 frame_sync_n_i,
	output logic                      word_vld_o,
	output logic [WORD_BITS-1:0]      word_o
);
	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [1:0]           sck_s_r;
	logic [1:0]           sdi_s_r;
	logic [1:0]           fs_s_r;
	logic                 sck_d_r;
	logic [WORD_BITS-1:0] shift_r;
	logic [CNT_W-1:0]     cnt_r;
	logic                 fall;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sck_s_r <= 2'h0;
			sdi_s_r <= 2'h0;
			fs_s_r  <= 2'h3;
			sck_d_r <= 1'b0;
		end else begin
			sck_s_r <= {sck_s_r[0], serial_clock_in_i};
			sdi_s_r <= {sdi_s_r[0], serial_data_in_i};
			fs_s_r  <= {fs_s_r[0], frame_sync_n_i};
			sck_d_r <= sck_s_r[1];
		end
	end

	assign fall = sck_d_r & ~sck_s_r[1];

	// ----------------------------------------
	// Shift and count
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		word_vld_o <= 1'b0;
		if (rst_i) begin
			shift_r <= '0;
			cnt_r   <= '0;
			word_o  <= '0;
		end else if (fs_s_r[1]) begin
			// Frame idle: traffic for other devices is ignored
			cnt_r <= '0;
		end else if (fall && cnt_r != CNT_FULL) begin
			shift_r <= {shift_r[WORD_BITS-2:0], sdi_s_r[1]};
			cnt_r   <= cnt_r + 5'h01;
			if (cnt_r == CNT_FULL - 5'h01) begin
				// Extra edges past sixteen are dropped until the frame ends
				word_vld_o <= 1'b1;
				word_o     <= {shift_r[WORD_BITS-2:0], sdi_s_r[1]};
			end
		end
	end
endmodule

// ---- dv/sdl_host_model.sv ----
// Purpose: Host serial port model
// Assumes: Clock idles low, data shifts on rise
// Notes:   Released data line shows the inverse
`timescale 1ns/100ps
module sdl_host_model (
	input  wire logic clk_i,
	output logic      sck_o,
	output logic      sdi_o,
	output logic      fs_n_o
);
	// Four reference clocks per half period make the 400 ns serial clock
	localparam int HALF = 4;

	initial begin
		sck_o  = 1'b0;
		sdi_o  = 1'b0;
		fs_n_o = 1'b1;
	end

	// Sends the top n bits of w; sel low leaves this frame sync idle
	task automatic send(input logic [15:0] w, input int n, input logic sel);
		@(posedge clk_i);
		fs_n_o <= !sel;
		repeat (HALF) @(posedge clk_i);
		for (int i = 15; i > 15 - n; i--) begin
			sck_o <= 1'b1;
			sdi_o <= w[i];
			repeat (HALF) @(posedge clk_i);
			sck_o <= 1'b0;
			repeat (HALF) @(posedge clk_i);
			if (i == 8) begin
				// Byte-wide port pauses between bytes with frame sync low
				repeat (2 * HALF) @(posedge clk_i);
			end
		end
		fs_n_o <= 1'b1;
		sdi_o  <= !sdi_o;
		repeat (2 * HALF) @(posedge clk_i);
	endtask
endmodule

// ---- dv/sdl_top_asserts.sv ----
// Purpose: Port checks for sdl_top
// Assumes: Inputs pass a 2-FF sync
// Notes:   Hold windows cover the sync delay
`timescale 1ns/100ps
module sdl_top_asserts
	import sdl_pkg::*;
#(parameter int CHANNELS = 8)(
	input wire logic                  ref_clk_i,
	input wire logic                  rst_i,
	input wire logic                  serial_clock_in_i,
	input wire logic                  serial_data_in_i,
	input wire logic                  frame_sync_n_i,
	input wire logic                  load_outputs_n_i,
	input wire logic                  clear_outputs_n_i,
	input wire logic [CHANNELS*10-1:0] dac_main_o,
	input wire logic [CHANNELS*10-1:0] dac_sub_o,
	input wire logic [CHANNELS*10-1:0] chan_ctrl_o,
	input wire logic [9:0]            sys_ctrl_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_quiet; (frame_sync_n_i && clear_outputs_n_i)[*8]; endsequence
	sequence s_held; (load_outputs_n_i && clear_outputs_n_i)[*6]; endsequence
	sequence s_clr; (!clear_outputs_n_i)[*6]; endsequence
	idle_chan_a: assert property (s_quiet |-> $stable(chan_ctrl_o))
		else $error("chan ctrl moved while idle");
	idle_sys_a: assert property (s_quiet |-> $stable(sys_ctrl_o))
		else $error("sys ctrl moved while idle");
	hold_main_a: assert property (s_held |-> $stable(dac_main_o))
		else $error("main moved without load");
	hold_sub_a: assert property (s_held |-> $stable(dac_sub_o))
		else $error("sub moved without load");
	clr_out_a: assert property (s_clr |-> dac_main_o == '0 && dac_sub_o == '0)
		else $error("outputs not cleared");
	clr_ctrl_a: assert property (s_clr |-> chan_ctrl_o == '0 && sys_ctrl_o == 10'h000)
		else $error("controls not cleared");
	// Sub lanes are eight bits wide, so no channel may show its top two bits
	logic sub_top_set;
	always_comb begin
		sub_top_set = 1'b0;
		for (int i = 0; i < CHANNELS; i++) begin
			sub_top_set = sub_top_set | dac_sub_o[i*10+8] | dac_sub_o[i*10+9];
		end
	end
	sub_width_a: assert property (!sub_top_set)
		else $error("sub upper bits set");
	rst_zero_a: assert property (disable iff (1'b0) rst_i |=> dac_main_o == '0)
		else $error("main not zero after reset");
endmodule
bind sdl_top sdl_top_asserts #(.CHANNELS(CHANNELS)) u_chk (.*);

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for sdl_top
// Assumes: Host model drives the serial pins
// Notes:   Expected latches are mirrored here
`timescale 1ns/100ps
module tb_top;
	import sdl_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ld_n = 1'b1;
	logic        clr_n = 1'b1;
	logic        sck, sdi, fs_n;
	logic [79:0] main, sub, cc, im = '0, is = '0, em = '0, es = '0, ec = '0;
	logic [9:0]  sc, esc = '0;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	always #25 ref_clk_i = ~ref_clk_i;
	sdl_host_model host(.clk_i(ref_clk_i), .sck_o(sck), .sdi_o(sdi), .fs_n_o(fs_n));
	sdl_top dut(.ref_clk_i(ref_clk_i), .rst_i(rst_i), .serial_clock_in_i(sck),
		.serial_data_in_i(sdi), .frame_sync_n_i(fs_n), .load_outputs_n_i(ld_n),
		.clear_outputs_n_i(clr_n), .dac_main_o(main), .dac_sub_o(sub),
		.chan_ctrl_o(cc), .sys_ctrl_o(sc));
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// Mirror every decoded word, then compare all four outputs
	task automatic put(input logic [15:0] w);
		int b;
		host.send(w, 16, 1'b1);
		b = w[12:10] * 10;
		case (w[15:13])
			3'h0: esc = w[9:0];
			3'h1: im[b+:10] = w[9:0];
			3'h2: ec[b+:10] = w[9:0];
			3'h5: is[b+:10] = {2'h0, w[7:0]};
			default: ;
		endcase
		if (!ld_n) begin
			em = im;
			es = is;
		end
		wt(12);
		chk(main, em);
		chk(sub, es);
		chk(cc, ec);
		chk(sc, esc);
	endtask
	task automatic t_auto();
		logic [15:0] ws [8] = '{16'h0060, 16'h4210, 16'h23FF, 16'hA3FF,
			16'h3D55, 16'hBC81, 16'h5FFF, 16'h6000};
		ld_n <= 1'b0;
		foreach (ws[i]) put(ws[i]);
		$display("auto done");
	endtask
	task automatic t_double();
		ld_n <= 1'b1;
		put(16'h2401);
		put(16'h2802);
		put(16'hA455);
		@(posedge ref_clk_i) ld_n <= 1'b0;
		wt(6);
		em = im;
		es = is;
		ld_n <= 1'b1;
		put(16'h0155);
		$display("double done");
	endtask
	task automatic t_frame();
		@(posedge ref_clk_i) ld_n <= 1'b0;
		host.send(16'h27AA, 9, 1'b1);
		host.send(16'h2BCD, 16, 1'b0);
		put(16'h2C33);
		$display("frame done");
	endtask
	task automatic t_clear();
		clr_n <= 1'b0;
		wt(8);
		{im, is, em, es, ec, esc} = '0;
		clr_n <= 1'b1;
		put(16'h0001);
		$display("clear done");
	endtask
	initial begin
		wt(5);
		rst_i <= 1'b0;
		wt(4);
		t_auto();
		t_double();
		t_frame();
		t_clear();
		results();
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end
endmodule
